// ---- verilog/dso_status_out.sv ----
// Operation
// R1 - Readiness is shown only with main power on, no hard-wired base block, no alarm, no forced stop; the code ignores it until detection completes.
// R2 - The first power-stage-on command after power-up starts polarity detection at once, and readiness returns at its completion without the forced-stop condition.
// R3 - Readiness means the power-stage-on command can be accepted, shown as a closed output, and the host waits for it.
// R4 - The speed match flag exists only in speed control and is set when the speed error is within the match width.
// R5 - The match width is the larger of the fixed width and the speed reference times the percentage width.
// R6 - The fixed width accepts 0 to 100 rpm, resets to 10 and acts at once.
// R7 - The percentage width accepts 10 to 50 percent, resets to 15 and acts at once.
// R8 - In position control the done flag is set while the deviation magnitude is at most the done width.
// R9 - The done width accepts 0 to 1073741824 units, resets to 7, acts at once and only affects the flag.
// R10 - Each flag reaches a terminal only through its own allocation digit.
// R11 - The user lowers the done width if the done flag shows spuriously at low speed.
// R12 - Digit 0 disables a flag, 1 to 3 pick a terminal and 4 to 6 are reserved.
// R13 - Flags sharing a terminal are ORed and a polarity bit of 1 inverts that terminal.
// R14 - All flags are re-evaluated every cycle with no filtering or hysteresis.
`timescale 1ns/1ps

module dso_status_out (
   // Clock and reset
   input  wire logic                ref_clk_i,
   input  wire logic                reset_i,
   // Register port
   input  wire logic [7:0]          reg_addr_i,
   input  wire logic [31:0]         reg_wr_data_i,
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   output logic      [31:0]         reg_rd_data_o,
   // Drive conditions
   input  wire logic                main_power_on_i,
   input  wire logic                base_block_i,
   input  wire logic                alarm_i,
   input  wire logic                forced_stop_state_i,
   input  wire logic                power_stage_on_command_i,
   input  wire logic                polarity_detect_done_i,
   output logic                     polarity_detect_start_o,
   // Control loop values
   input  wire logic [1:0]          control_mode_i,
   input  wire logic signed [15:0]  ref_speed_i,
   input  wire logic signed [15:0]  motor_speed_i,
   input  wire logic signed [31:0]  deviation_count_i,
   // Flags and terminals
   output logic                     servo_ready_flag_o,
   output logic                     speed_match_flag_o,
   output logic                     position_done_flag_o,
   output logic      [2:0]          terminal_closed_o,
   // Interrupt
   output logic                     irq_o
);

   // ----------------------------------------------------------------------
   // Settings and interrupt registers.
   // ----------------------------------------------------------------------
   logic [6:0]  fixed_speed_match_width;
   logic [5:0]  percent_speed_match_width;
   logic [30:0] position_done_width;
   logic [15:0] output_allocation_setting;
   logic [2:0]  output_polarity_setting;
   logic [2:0]  irq_status;
   logic [2:0]  irq_enable;
   logic [31:0] rd_data;
   logic [6:0]  next_fixed_speed_match_width;
   logic [5:0]  next_percent_speed_match_width;
   logic [30:0] next_position_done_width;
   logic [15:0] next_output_allocation_setting;
   logic [2:0]  next_output_polarity_setting;
   logic [2:0]  next_irq_status;
   logic [2:0]  next_irq_enable;
   logic [31:0] next_rd_data;
   logic [2:0]  flag_rise;
   logic [2:0]  irq_clear;

   // ----------------------------------------------------------------------
   // Readiness sequencing and flags.
   // ----------------------------------------------------------------------
   dso_pkg::dso_ready_state_t state;
   dso_pkg::dso_ready_state_t next_state;
   logic                      detect_start;
   logic                      next_detect_start;
   logic                      ready_flag;
   logic                      speed_flag;
   logic                      pos_flag;
   logic [2:0]                terminals;
   logic [2:0]                next_terminals;
   logic                      speed_hit;
   logic                      base_ok;
   logic [31:0]               abs_dev;

   dso_flags_if flags_next ();

   // ----------------------------------------------------------------------
   // Register writes and reads.
   // ----------------------------------------------------------------------
   always_comb begin
      next_fixed_speed_match_width   = fixed_speed_match_width;
      next_percent_speed_match_width = percent_speed_match_width;
      next_position_done_width       = position_done_width;
      next_output_allocation_setting = output_allocation_setting;
      next_output_polarity_setting   = output_polarity_setting;
      next_irq_enable                = irq_enable;
      irq_clear                      = 3'h0;
      next_rd_data                   = 32'h0000_0000;
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            dso_pkg::OFF_FIXED_WIDTH: begin
               // Writes above the range saturate at the top value.
               if (reg_wr_data_i > 32'(dso_pkg::FIXED_WIDTH_MAX)) begin
                  next_fixed_speed_match_width = dso_pkg::FIXED_WIDTH_MAX; // [R6]
               end else begin
                  next_fixed_speed_match_width = reg_wr_data_i[6:0]; // [R6]
               end
            end
            dso_pkg::OFF_PERCENT_WIDTH: begin
               if (reg_wr_data_i < 32'(dso_pkg::PERCENT_MIN)) begin
                  next_percent_speed_match_width = dso_pkg::PERCENT_MIN; // [R7]
               end else if (reg_wr_data_i > 32'(dso_pkg::PERCENT_MAX)) begin
                  next_percent_speed_match_width = dso_pkg::PERCENT_MAX; // [R7]
               end else begin
                  next_percent_speed_match_width = reg_wr_data_i[5:0]; // [R7]
               end
            end
            dso_pkg::OFF_POS_WIDTH: begin
               if (reg_wr_data_i > 32'(dso_pkg::POS_WIDTH_MAX)) begin
                  next_position_done_width = dso_pkg::POS_WIDTH_MAX; // [R9]
               end else begin
                  next_position_done_width = reg_wr_data_i[30:0]; // [R9]
               end
            end
            dso_pkg::OFF_ALLOCATION: next_output_allocation_setting = reg_wr_data_i[15:0];
            dso_pkg::OFF_POLARITY:   next_output_polarity_setting   = reg_wr_data_i[2:0];
            dso_pkg::OFF_IRQ_CLEAR:  irq_clear                      = reg_wr_data_i[2:0];
            dso_pkg::OFF_IRQ_ENABLE: next_irq_enable                = reg_wr_data_i[2:0];
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            dso_pkg::OFF_FIXED_WIDTH:   next_rd_data = 32'(fixed_speed_match_width);
            dso_pkg::OFF_PERCENT_WIDTH: next_rd_data = 32'(percent_speed_match_width);
            dso_pkg::OFF_POS_WIDTH:     next_rd_data = 32'(position_done_width);
            dso_pkg::OFF_ALLOCATION:    next_rd_data = 32'(output_allocation_setting);
            dso_pkg::OFF_POLARITY:      next_rd_data = 32'(output_polarity_setting);
            dso_pkg::OFF_STATUS: begin
               next_rd_data[dso_pkg::BIT_READY]                = ready_flag;
               next_rd_data[dso_pkg::BIT_SPEED_MATCH]          = speed_flag;
               next_rd_data[dso_pkg::BIT_POS_DONE]             = pos_flag;
               next_rd_data[dso_pkg::STAT_TERM_LSB +: 3]       = terminals;
               next_rd_data[dso_pkg::STAT_STATE_LSB +: 3]      = state;
            end
            dso_pkg::OFF_IRQ_STATUS:    next_rd_data = 32'(irq_status);
            dso_pkg::OFF_IRQ_ENABLE:    next_rd_data = 32'(irq_enable);
            default:                    next_rd_data = 32'h0000_0000;
         endcase
      end
      // A rising flag in the clearing cycle keeps its status bit set.
      next_irq_status = (irq_status & ~irq_clear) | flag_rise;
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         fixed_speed_match_width   <= dso_pkg::RST_FIXED_WIDTH; // [R6]
         percent_speed_match_width <= dso_pkg::RST_PERCENT_WIDTH; // [R7]
         position_done_width       <= dso_pkg::RST_POS_WIDTH; // [R9]
         output_allocation_setting <= dso_pkg::RST_ALLOCATION;
         output_polarity_setting   <= dso_pkg::RST_POLARITY;
         irq_status                <= 3'h0;
         irq_enable                <= dso_pkg::RST_IRQ_ENABLE;
         rd_data                   <= 32'h0000_0000;
      end else begin
         fixed_speed_match_width   <= next_fixed_speed_match_width;
         percent_speed_match_width <= next_percent_speed_match_width;
         position_done_width       <= next_position_done_width;
         output_allocation_setting <= next_output_allocation_setting;
         output_polarity_setting   <= next_output_polarity_setting;
         irq_status                <= next_irq_status;
         irq_enable                <= next_irq_enable;
         rd_data                   <= next_rd_data;
      end
   end

   assign reg_rd_data_o = rd_data;
   assign irq_o         = |(irq_status & irq_enable);

   // ----------------------------------------------------------------------
   // First power-stage-on after power-up.
   // ----------------------------------------------------------------------
   assign base_ok = main_power_on_i && !base_block_i && !alarm_i;

   always_comb begin
      next_state        = state;
      next_detect_start = 1'b0;
      unique case (state)
         dso_pkg::ST_FIRST_WAIT: begin
            if (power_stage_on_command_i) begin
               next_state        = dso_pkg::ST_DETECT; // [R2]
               next_detect_start = 1'b1; // [R2]
            end
         end
         dso_pkg::ST_DETECT: begin
            if (polarity_detect_done_i) begin
               next_state = dso_pkg::ST_RUN; // [R2]
            end
         end
         dso_pkg::ST_RUN: next_state = dso_pkg::ST_RUN;
      endcase
   end

   // ----------------------------------------------------------------------
   // Flag conditions, evaluated every cycle.
   // ----------------------------------------------------------------------
   dso_speed_cmp u_speed_cmp (
      .ref_speed_i     (ref_speed_i),
      .motor_speed_i   (motor_speed_i),
      .fixed_width_i   (fixed_speed_match_width),
      .percent_width_i (percent_speed_match_width),
      .match_o         (speed_hit)
   );

   always_comb begin
      abs_dev = deviation_count_i[31] ? 32'(-deviation_count_i) : 32'(deviation_count_i);
      flags_next.ready = 1'b0;
      unique case (state)
         // Forced stop is ignored here; the command itself drops readiness for detection.
         dso_pkg::ST_FIRST_WAIT: flags_next.ready = base_ok && !power_stage_on_command_i; // [R2] [R3]
         // Readiness comes back when detection completes.
         dso_pkg::ST_DETECT:     flags_next.ready = base_ok && polarity_detect_done_i; // [R2]
         dso_pkg::ST_RUN:        flags_next.ready = base_ok && !forced_stop_state_i; // [R1] [R3]
      endcase
      flags_next.speed_match = (control_mode_i == dso_pkg::MODE_SPEED) && speed_hit; // [R4] [R14]
      flags_next.pos_done    = (control_mode_i == dso_pkg::MODE_POSITION) &&
                               (abs_dev <= {1'b0, position_done_width}); // [R8] [R14]
   end

   dso_out_map u_out_map (
      .flags        (flags_next),
      .allocation_i (output_allocation_setting),
      .polarity_i   (output_polarity_setting),
      .closed_o     (next_terminals)
   );

   assign flag_rise = {flags_next.pos_done && !pos_flag,
                       flags_next.speed_match && !speed_flag,
                       flags_next.ready && !ready_flag};

   // ----------------------------------------------------------------------
   // Registered flags, terminals and sequencing.
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state        <= dso_pkg::ST_FIRST_WAIT;
         detect_start <= 1'b0;
         ready_flag   <= 1'b0;
         speed_flag   <= 1'b0;
         pos_flag     <= 1'b0;
         terminals    <= 3'h0;
      end else begin
         state        <= next_state;
         detect_start <= next_detect_start;
         ready_flag   <= flags_next.ready; // [R14]
         speed_flag   <= flags_next.speed_match; // [R14]
         pos_flag     <= flags_next.pos_done; // [R14]
         terminals    <= next_terminals; // [R10] [R13]
      end
   end

   assign polarity_detect_start_o = detect_start;
   assign servo_ready_flag_o      = ready_flag;
   assign speed_match_flag_o      = speed_flag;
   assign position_done_flag_o    = pos_flag;
   assign terminal_closed_o       = terminals;

endmodule : dso_status_out

// ---- verilog/dso_pkg.sv ----
package dso_pkg;

   // ------
   // Register bus.
   // ------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   localparam logic [7:0] OFF_FIXED_WIDTH   = 8'h00;
   localparam logic [7:0] OFF_PERCENT_WIDTH = 8'h04;
   localparam logic [7:0] OFF_POS_WIDTH     = 8'h08;
   localparam logic [7:0] OFF_ALLOCATION    = 8'h0C;
   localparam logic [7:0] OFF_POLARITY      = 8'h10;
   localparam logic [7:0] OFF_STATUS        = 8'h14;
   localparam logic [7:0] OFF_IRQ_STATUS    = 8'h18;
   localparam logic [7:0] OFF_IRQ_CLEAR     = 8'h1C;
   localparam logic [7:0] OFF_IRQ_ENABLE    = 8'h20;

   // ------
   // Setting ranges and values after reset.
   // ------
   localparam logic [6:0]  RST_FIXED_WIDTH   = 7'h0A;
   localparam logic [6:0]  FIXED_WIDTH_MAX   = 7'h64;
   localparam logic [5:0]  RST_PERCENT_WIDTH = 6'h0F;
   localparam logic [5:0]  PERCENT_MIN       = 6'h0A;
   localparam logic [5:0]  PERCENT_MAX       = 6'h32;
   localparam logic [30:0] RST_POS_WIDTH     = 31'h0000_0007;
   localparam logic [30:0] POS_WIDTH_MAX     = 31'h4000_0000;
   localparam logic [15:0] RST_ALLOCATION    = 16'h0000;
   localparam logic [2:0]  RST_POLARITY      = 3'h0;
   localparam logic [2:0]  RST_IRQ_ENABLE    = 3'h0;
   localparam logic [6:0]  PERCENT_SCALE     = 7'h64;

   // ------
   // Output allocation digits and terminals.
   // ------
   localparam int unsigned NUM_TERMINALS = 3;
   localparam int unsigned ALLOC_POS_LSB = 0;
   localparam int unsigned ALLOC_SPD_LSB = 4;
   localparam int unsigned ALLOC_RDY_LSB = 12;
   localparam logic [3:0]  ALLOC_OFF     = 4'h0;

   // ------
   // Status and interrupt bit positions.
   // ------
   localparam int unsigned BIT_READY       = 0;
   localparam int unsigned BIT_SPEED_MATCH = 1;
   localparam int unsigned BIT_POS_DONE    = 2;
   localparam int unsigned STAT_TERM_LSB   = 4;
   localparam int unsigned STAT_STATE_LSB  = 8;

   // ------
   // Control modes and readiness states.
   // ------
   localparam logic [1:0] MODE_SPEED    = 2'h1;
   localparam logic [1:0] MODE_POSITION = 2'h2;

   typedef enum logic [2:0] {
      ST_FIRST_WAIT = 3'h1,
      ST_DETECT     = 3'h2,
      ST_RUN        = 3'h4
   } dso_ready_state_t;

endpackage : dso_pkg

// ---- verilog/dso_flags_if.sv ----
`timescale 1ns/1ps

// Next values of the three condition flags, passed to the terminal mapper.
interface dso_flags_if;
   logic ready;
   logic speed_match;
   logic pos_done;

   modport src (output ready, output speed_match, output pos_done);
   modport dst (input ready, input speed_match, input pos_done);
endinterface : dso_flags_if

// ---- verilog/dso_speed_cmp.sv ----
`timescale 1ns/1ps

// Compares motor speed with the reference speed; both sides are scaled by 100
// so the percentage term needs no divider.
module dso_speed_cmp (
   // Speeds in rpm
   input  wire logic signed [15:0] ref_speed_i,
   input  wire logic signed [15:0] motor_speed_i,
   // Width settings
   input  wire logic        [6:0]  fixed_width_i,
   input  wire logic        [5:0]  percent_width_i,
   // Result
   output logic                    match_o
);
   logic signed [16:0] diff;
   logic        [16:0] abs_diff;
   logic        [15:0] abs_ref;
   logic        [23:0] lhs;
   logic        [23:0] pct_term;
   logic        [23:0] fix_term;
   logic        [23:0] window;

   always_comb begin
      diff     = 17'(ref_speed_i) - 17'(motor_speed_i);
      abs_diff = diff[16] ? 17'(-diff) : 17'(diff);
      abs_ref  = ref_speed_i[15] ? 16'(-ref_speed_i) : 16'(ref_speed_i);
      lhs      = 24'(abs_diff) * 24'(dso_pkg::PERCENT_SCALE);
      pct_term = 24'(abs_ref) * 24'(percent_width_i);
      fix_term = 24'(fixed_width_i) * 24'(dso_pkg::PERCENT_SCALE);
      window   = (pct_term > fix_term) ? pct_term : fix_term; // [R5]
      match_o  = (lhs <= window); // [R4]
   end

endmodule : dso_speed_cmp

// ---- verilog/dso_out_map.sv ----
`timescale 1ns/1ps

// Routes each flag to the terminal its allocation digit selects.
module dso_out_map (
   // Flags
   dso_flags_if.dst          flags,
   // Settings
   input  wire logic [15:0] allocation_i,
   input  wire logic [2:0]  polarity_i,
   // Terminal levels, 1 = closed
   output logic      [2:0]  closed_o
);
   logic [3:0] rdy_digit;
   logic [3:0] spd_digit;
   logic [3:0] pos_digit;

   assign rdy_digit = allocation_i[dso_pkg::ALLOC_RDY_LSB +: 4]; // [R10]
   assign spd_digit = allocation_i[dso_pkg::ALLOC_SPD_LSB +: 4]; // [R10]
   assign pos_digit = allocation_i[dso_pkg::ALLOC_POS_LSB +: 4]; // [R10]

   // Digit 0 and the reserved digits 4 to 6 match no terminal.
   for (genvar t = 0; t < dso_pkg::NUM_TERMINALS; t++) begin : g_term
      localparam logic [3:0] SEL = 4'(t + 1);
      logic raw;
      assign raw = (flags.ready && rdy_digit == SEL) ||
                   (flags.speed_match && spd_digit == SEL) ||
                   (flags.pos_done && pos_digit == SEL); // [R12] [R13]
      assign closed_o[t] = raw ^ polarity_i[t]; // [R13]
   end

endmodule : dso_out_map

// ---- tb/dso_status_out_props.sv ----
`timescale 1ns/1ps

module dso_status_out_props (
   // Clock, reset and drive conditions
   input  wire logic               ref_clk_i,
   input  wire logic               reset_i,
   input  wire logic               main_power_on_i,
   input  wire logic               base_block_i,
   input  wire logic               alarm_i,
   input  wire logic               power_stage_on_command_i,
   input  wire logic [1:0]         control_mode_i,
   input  wire logic signed [15:0] ref_speed_i,
   input  wire logic signed [15:0] motor_speed_i,
   input  wire logic signed [31:0] deviation_count_i,
   // Outputs watched
   input  wire logic               polarity_detect_start_o,
   input  wire logic               servo_ready_flag_o,
   input  wire logic               speed_match_flag_o,
   input  wire logic               position_done_flag_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   sequence s_detect_start;
      polarity_detect_start_o;
   endsequence
   sequence s_fault_seen;
      alarm_i || base_block_i || !main_power_on_i;
   endsequence

   chk_ready_fault: assert property (s_fault_seen |=> !servo_ready_flag_o)
      else $error("readiness shown during a fault");
   chk_start_cause: assert property (s_detect_start |-> $past(power_stage_on_command_i))
      else $error("detection start without a power stage on command");
   chk_start_ready: assert property (s_detect_start |-> !servo_ready_flag_o)
      else $error("readiness shown as detection starts");
   chk_start_single: assert property (s_detect_start |=> !polarity_detect_start_o [*3])
      else $error("detection start longer than one cycle");
   chk_speed_mode: assert property (control_mode_i != dso_pkg::MODE_SPEED |=> !speed_match_flag_o)
      else $error("speed match outside speed control");
   chk_speed_equal: assert property (control_mode_i == dso_pkg::MODE_SPEED
      && ref_speed_i == motor_speed_i |=> speed_match_flag_o)
      else $error("speed match missing at equal speeds");
   chk_pos_mode: assert property (control_mode_i != dso_pkg::MODE_POSITION
      |=> !position_done_flag_o) else $error("position done outside position control");
   chk_pos_zero: assert property (control_mode_i == dso_pkg::MODE_POSITION
      && deviation_count_i == 0 |=> position_done_flag_o) else $error("position done missing");
endmodule : dso_status_out_props

bind dso_status_out dso_status_out_props u_props (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
   .main_power_on_i(main_power_on_i), .base_block_i(base_block_i), .alarm_i(alarm_i),
   .power_stage_on_command_i(power_stage_on_command_i), .control_mode_i(control_mode_i),
   .ref_speed_i(ref_speed_i), .motor_speed_i(motor_speed_i),
   .deviation_count_i(deviation_count_i), .polarity_detect_start_o(polarity_detect_start_o),
   .servo_ready_flag_o(servo_ready_flag_o), .speed_match_flag_o(speed_match_flag_o),
   .position_done_flag_o(position_done_flag_o));

// ---- tb/dso_host_model.sv ----
`timescale 1ns/1ps

module dso_host_model (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic reset_i,
   // Handshake
   input  wire logic enable_i,
   input  wire logic ready_i,
   output logic      power_stage_on_command_o
);
   // The command is raised only once readiness has been seen, then held as a level.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !enable_i) begin
         power_stage_on_command_o <= 1'b0;
      end else if (ready_i) begin
         power_stage_on_command_o <= 1'b1;
      end
   end
endmodule : dso_host_model

// ---- tb/dso_status_out_test.sv ----
`timescale 1ns/1ps

module dso_status_out_test;
   typedef struct {logic [31:0] exp; logic [31:0] mask;} dso_note_t;
   logic               clk, rst, wr, rd, rd_d, pw, bb, al, fs, cmd, dn, st_o, en;
   logic               rdy_o, spd_o, pos_o, irq_o;
   logic [7:0]         addr;
   logic [31:0]        wdat, rdat, rng;
   logic [1:0]         mode;
   logic signed [15:0] rs, ms;
   logic signed [31:0] dev;
   logic [2:0]         term_o;
   int                 fail_count, compares, i;
   int                 rows[13][4] = '{'{1, 2000, 1800, 0}, '{1, 2000, 1799, 0}, '{1, 2000, 2200, 0},
      '{1, 2000, 2201, 0}, '{1, 300, 200, 0}, '{1, 300, 199, 0}, '{1, 300, 401, 0},
      '{1, -2000, -1800, 0}, '{1, 0, 100, 0}, '{2, 0, 0, 7}, '{2, 0, 0, -8}, '{3, 9, 9, 0},
      '{1, 500, 500, 0}};
   logic [19:0]        alloc[4] = '{20'h3021_0, 20'h3021_3, 20'h1011_0, 20'h5050_4};
   logic [2:0]         term_e[4] = '{3'h5, 3'h6, 3'h1, 3'h4};
   dso_note_t          notes[$];

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   dso_status_out dut (.ref_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wr_data_i(wdat),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rd_data_o(rdat), .main_power_on_i(pw),
      .base_block_i(bb), .alarm_i(al), .forced_stop_state_i(fs), .power_stage_on_command_i(cmd),
      .polarity_detect_done_i(dn), .polarity_detect_start_o(st_o), .control_mode_i(mode),
      .ref_speed_i(rs), .motor_speed_i(ms), .deviation_count_i(dev), .servo_ready_flag_o(rdy_o),
      .speed_match_flag_o(spd_o), .position_done_flag_o(pos_o), .terminal_closed_o(term_o),
      .irq_o(irq_o));
   dso_host_model u_host (.ref_clk_i(clk), .reset_i(rst), .enable_i(en), .ready_i(rdy_o),
      .power_stage_on_command_o(cmd));

   // ------
   // Shared tasks
   // ------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdat <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      notes.push_back('{e & m, m});
      @(posedge clk);
      rd <= 1'b0;
   endtask : rreg
   task automatic cond(input logic p, input logic b, input logic a, input logic f, input logic d);
      @(posedge clk);
      {pw, bb, al, fs, dn} <= {p, b, a, f, d};
      rreg(8'h14, 32'h0, 32'h0);
   endtask : cond
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   task automatic flags(input int m, input int r, input int mo, input int dv, input int w);
      logic [31:0] e;
      int          d;
      int          pw_;
      d = (r > mo) ? r - mo : mo - r;
      pw_ = ((r < 0) ? -r : r) * 10;
      e = 32'h0;
      e[1] = (m == 1) && (d * 100 <= ((pw_ > 10000) ? pw_ : 10000));
      e[2] = (m == 2) && (dv <= w) && (-dv <= w);
      @(posedge clk);
      mode <= m[1:0];
      rs <= r[15:0];
      ms <= mo[15:0];
      dev <= dv;
      rreg(8'h14, e, 32'h6);
   endtask : flags
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   // ------
   // Read monitor: each read answer is compared with the oldest note.
   // ------
   always @(posedge clk) rd_d <= rd;
   always @(negedge clk) begin
      dso_note_t n;
      if (rd_d === 1'b1) begin
         if (notes.size() == 0) begin
            chk("note queue", 32'h1, 32'h0);
         end else begin
            n = notes.pop_front();
            chk("read data", n.exp, rdat & n.mask);
         end
      end
   end

   initial begin
      {rst, wr, rd, rd_d, pw, bb, al, fs, dn, en, mode} = '0;
      rst = 1'b1;
      {addr, wdat, rs, ms, dev} = '0;
      rng = 32'h0000_B81C;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rreg(8'h00, 32'h0A, 32'hFFFF_FFFF);
      rreg(8'h04, 32'h0F, 32'hFFFF_FFFF);
      rreg(8'h08, 32'h07, 32'hFFFF_FFFF);
      rreg(8'h0C, 32'h00, 32'hFFFF_FFFF);
      for (i = 16; i <= 36; i += 4) rreg(i[7:0], (i == 20) ? 32'h100 : 32'h0, 32'hFFFF_FFFF);
      $display("reset values done");
      cond(0, 0, 0, 1, 0); notes[$] = '{32'h0, 32'h1};
      cond(1, 0, 0, 1, 0); notes[$] = '{32'h101, 32'h701};
      cond(1, 1, 0, 1, 0); notes[$] = '{32'h0, 32'h1};
      cond(1, 0, 0, 1, 0); notes[$] = '{32'h101, 32'h701};
      en <= 1'b1;
      for (i = 0; i < 20 && st_o !== 1'b1; i++) @(posedge clk);
      if (i == 20) begin
         chk("detection start", 32'h1, 32'h0);
         end_sim();
      end
      cond(1, 0, 0, 1, 0); notes[$] = '{32'h200, 32'h701};
      cond(1, 0, 0, 1, 1); notes[$] = '{32'h401, 32'h701};
      cond(1, 0, 0, 1, 0); notes[$] = '{32'h0, 32'h1};
      cond(1, 0, 1, 0, 0); notes[$] = '{32'h0, 32'h1};
      cond(1, 0, 0, 0, 0); notes[$] = '{32'h1, 32'h1};
      $display("readiness done");
      wreg(8'h00, 32'hC8);
      wreg(8'h04, 32'h05);
      rreg(8'h00, 32'h64, 32'hFFFF_FFFF);
      rreg(8'h04, 32'h0A, 32'hFFFF_FFFF);
      for (i = 0; i < 13; i++) flags(rows[i][0], rows[i][1], rows[i][2], rows[i][3], 7);
      for (i = 0; i < 24; i++) begin
         rng = xs(rng);
         flags(rng[20:19], $signed(rng[10:0]), $signed(rng[10:0]) + $signed(rng[18:11]),
            $signed(rng[24:21]), 7);
      end
      wreg(8'h08, 32'h03);
      flags(2, 0, 0, 4, 3);
      flags(2, 0, 0, -3, 3);
      wreg(8'h04, 32'h3C);
      wreg(8'h08, 32'hFFFF_FFFF);
      rreg(8'h04, 32'h32, 32'hFFFF_FFFF);
      rreg(8'h08, 32'h4000_0000, 32'hFFFF_FFFF);
      $display("flags done");
      for (i = 0; i < 4; i++) begin
         wreg(8'h0C, {16'h0, alloc[i][19:4]});
         wreg(8'h10, {29'h0, alloc[i][2:0]});
         rreg(8'h14, {25'h0, term_e[i], 4'h0}, 32'h70);
         chk("terminals", {29'h0, term_e[i]}, {29'h0, term_o});
      end
      $display("terminals done");
      wreg(8'h20, 32'h4);
      wreg(8'h1C, 32'h7);
      flags(1, 0, 0, 0, 0);
      flags(2, 0, 0, 5, 32'h4000_0000);
      rreg(8'h18, 32'h4, 32'h4);
      chk("irq raised", 32'h1, {31'h0, irq_o});
      wreg(8'h20, 32'h0);
      #1 chk("irq masked", 32'h0, {31'h0, irq_o});
      wreg(8'h1C, 32'h4);
      rreg(8'h18, 32'h0, 32'h4);
      $display("interrupt done");
      repeat (3) @(posedge clk);
      chk("notes left", 32'h0, notes.size());
      end_sim();
   end
endmodule : dso_status_out_test
